// ---- rtl/pgc_pkg.sv ----
// Package for the generator channel control block: register map, fields, types
package pgc_pkg;
	// Register word offsets (byte addresses over Avalon-MM, word aligned)
	localparam logic [4:0] OFF_CONTROL = 5'h00;
	localparam logic [4:0] OFF_DUTY = 5'h04;
	localparam logic [4:0] OFF_PHASE = 5'h08;
	localparam logic [4:0] OFF_DEAD = 5'h0c;
	localparam logic [4:0] OFF_ALT_DEAD = 5'h10;
	localparam logic [4:0] OFF_TRIGGER = 5'h14;
	localparam logic [4:0] OFF_PIN_IO = 5'h18;
	localparam logic [4:0] OFF_FAULT_LIMIT = 5'h1c;
	// Reset value of every register
	localparam logic [15:0] REG_RESET = 16'h0000;
	// Control register fields
	localparam int CTL_LIMIT_PEND = 14;
	localparam int CTL_TRIG_PEND = 13;
	localparam int CTL_LIMIT_IEN = 11;
	localparam int CTL_TRIG_IEN = 10;
	localparam int CTL_OWN_PERIOD = 9;
	localparam int CTL_SHARED_DUTY = 8;
	localparam int CTL_DTC_LO = 6;
	localparam int CTL_LIMIT_RESET = 1;
	localparam int CTL_INSTANT = 0;
	// Writable masks per register
	localparam logic [15:0] CTL_WMASK = 16'h0fc3;
	localparam logic [15:0] PHASE_WMASK = 16'hfffc;
	localparam logic [15:0] DEAD_WMASK = 16'h3ffc;
	localparam logic [15:0] TRIG_WMASK = 16'he03f;
	localparam logic [15:0] PIN_WMASK = 16'hfffd;
	localparam logic [15:0] FCL_WMASK = 16'h1fff;
	// Phase bits kept when used as own period
	localparam logic [15:0] PERIOD_MASK = 16'hfff0;
	// Trigger register fields
	localparam int TRG_DIV_LO = 13;
	// Pin register fields
	localparam int PIN_HI_OWN = 15;
	localparam int PIN_LO_OWN = 14;
	localparam int PIN_HI_INV = 13;
	localparam int PIN_LO_INV = 12;
	localparam int PIN_MODE_LO = 10;
	localparam int PIN_HI_OVR = 9;
	localparam int PIN_LO_OVR = 8;
	localparam int PIN_OVR_LO = 6;
	localparam int PIN_FLT_LO = 4;
	localparam int PIN_LIM_LO = 2;
	localparam int PIN_OVERRIDE_SYNC = 0;
	// Fault / limit register fields
	localparam int FCL_LSRC_LO = 9;
	localparam int FCL_LINV = 8;
	localparam int FCL_LEN = 7;
	localparam int FCL_FSRC_LO = 3;
	localparam int FCL_FINV = 2;
	localparam int FCL_FMOD_LO = 0;
	// Fault response codes
	localparam logic [1:0] FMOD_FORCE = 2'h1;
	localparam logic [1:0] FMOD_OFF = 2'h3;

	// Dead-time modes
	typedef enum logic [1:0] {
		DT_POSITIVE = 2'b00,
		DT_NEGATIVE = 2'b01,
		DT_DISABLED = 2'b10,
		DT_RESERVED = 2'b11
	} pgc_dead_mode_t;

	// Pin pair modes
	typedef enum logic [1:0] {
		PM_COMPLEMENT = 2'b00,
		PM_INDEPENDENT = 2'b01,
		PM_PUSH_PULL = 2'b10,
		PM_RESERVED = 2'b11
	} pgc_pair_mode_t;

	// Settings handed to the waveform core
	typedef struct packed {
		logic own_period_select;
		logic [15:0] period;
		logic [15:0] duty;
		pgc_dead_mode_t dead_mode;
		logic [15:0] dead_time;
		logic [15:0] alt_dead_time;
		pgc_pair_mode_t pair_mode;
	} pgc_core_cfg_t;

	// Event inputs from the waveform core and the time base
	typedef struct packed {
		logic cycle_start;
		logic trigger_event;
		logic [5:0] roll_count;
	} pgc_core_evt_t;
endpackage : pgc_pkg

// ---- rtl/pgc_channel.sv ----
// Control logic for one channel of the switching pulse-width generator
// Operation
// - Clearing limit enable drops pending limit flag
// - Trigger enable lets triggers raise interrupt requests
// - Own-period bit selects phase register period
// - Shared-duty bit selects master duty value
// - Dead-time field: positive, negative, disabled, reserved
// - Limit source resets own time base
// - Instant load applies duty now, else cycle
// - Phase bits 15:2; period ignores bits 3:2
// - Dead-time registers hold bits 13:2 only
// - Trigger divider emits every (value+1)th event
// - Postscaler starts after start value matches roll
// - Ownership bits hand pins to generator
// - Polarity bits make pins active low
// - Pair mode: complementary, independent, push-pull
// - Override enables drive override value bits
// - Active fault drives fault pin values
// - Active limit drives limit pin values
// - Override sync applies overrides per cycle
// - Limit source select picks comparator or fault
// - Limit polarity bit inverts selected source
// - Limit enable bit turns function on
// - Fault response forces pins or disables input
// - Fault polarity bit inverts selected source
module pgc_channel
	import pgc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:0] i_master_duty,
	input wire logic [15:0] i_primary_period,
	input wire pgc_core_evt_t i_evt,
	input wire logic i_gen_high,
	input wire logic i_gen_low,
	input wire logic i_gpio_high,
	input wire logic i_gpio_low,
	input wire logic [3:0] i_comparator,
	input wire logic [3:0] i_shared_fault,
	input wire logic [3:0] i_indep_fault,
	output pgc_core_cfg_t o_core_cfg,
	output logic o_timebase_reset,
	output logic o_trigger_out,
	output logic o_limit_irq,
	output logic o_trigger_irq,
	output logic o_high_side_output,
	output logic o_low_side_output,
	output logic o_high_pin_owner,
	output logic o_low_pin_owner
);
	logic [15:0] control_ff, duty_ff, active_duty_ff, phase_ff, dead_ff, alt_dead_ff;
	logic [15:0] trigger_ff, pin_ff, fcl_ff;
	logic [1:0] active_ovr_ff;
	logic [2:0] post_count_ff;
	logic post_run_ff, trig_out_ff, ack_ff;
	logic [31:0] readdata_ff;
	logic high_ff, low_ff;

	// Bus decode: one wait cycle, then the acknowledge cycle
	wire access = (avs_read | avs_write) & ~ack_ff;
	wire wr_stb = avs_write & ack_ff;
	wire wr_ctl = wr_stb & (avs_address == OFF_CONTROL);
	wire wr_duty = wr_stb & (avs_address == OFF_DUTY);
	wire wr_phase = wr_stb & (avs_address == OFF_PHASE);
	wire wr_dead = wr_stb & (avs_address == OFF_DEAD);
	wire wr_alt = wr_stb & (avs_address == OFF_ALT_DEAD);
	wire wr_trig = wr_stb & (avs_address == OFF_TRIGGER);
	wire wr_pin = wr_stb & (avs_address == OFF_PIN_IO);
	wire wr_fcl = wr_stb & (avs_address == OFF_FAULT_LIMIT);
	wire [15:0] bemask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [15:0] wdata = avs_writedata[15:0];
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata = readdata_ff;

	// Masked merge of a write into a register image
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask,
		input logic [15:0] be, input logic [15:0] d);
		merge = (old & ~(wmask & be)) | (d & wmask & be);
	endfunction : merge

	// Current-limit source select and polarity
	logic limit_src;
	wire [3:0] lsrc = fcl_ff[FCL_LSRC_LO +: 4];
	always_comb begin
		unique case (lsrc)
			4'h0, 4'h1, 4'h2, 4'h3: limit_src = i_comparator[lsrc[1:0]];
			4'h8, 4'h9, 4'ha, 4'hb: limit_src = i_shared_fault[lsrc[1:0]];
			4'hd: limit_src = i_indep_fault[1];
			4'hf: limit_src = i_indep_fault[3];
			default: limit_src = 1'b0;
		endcase
	end
	wire limit_active = (limit_src ^ fcl_ff[FCL_LINV]) & fcl_ff[FCL_LEN];

	// Fault source select, same code map as the limit source
	logic fault_src;
	wire [3:0] fsrc = fcl_ff[FCL_FSRC_LO +: 4];
	always_comb begin
		unique case (fsrc)
			4'h0, 4'h1, 4'h2, 4'h3: fault_src = i_comparator[fsrc[1:0]];
			4'h8, 4'h9, 4'ha, 4'hb: fault_src = i_shared_fault[fsrc[1:0]];
			4'hd: fault_src = i_indep_fault[1];
			4'hf: fault_src = i_indep_fault[3];
			default: fault_src = 1'b0;
		endcase
	end
	wire [1:0] fmod = fcl_ff[FCL_FMOD_LO +: 2];
	wire fault_active = (fault_src ^ fcl_ff[FCL_FINV]) & (fmod == FMOD_FORCE);

	// Core settings
	wire [15:0] phase_period = phase_ff & PERIOD_MASK;
	wire [15:0] period_sel = control_ff[CTL_OWN_PERIOD] ? phase_period
		: i_primary_period;
	wire [15:0] duty_sel = control_ff[CTL_SHARED_DUTY] ? i_master_duty
		: active_duty_ff;
	// One driver for the whole settings word
	assign o_core_cfg = '{
		own_period_select: control_ff[CTL_OWN_PERIOD],
		period: period_sel,
		duty: duty_sel,
		dead_mode: pgc_dead_mode_t'(control_ff[CTL_DTC_LO +: 2]),
		dead_time: dead_ff,
		alt_dead_time: alt_dead_ff,
		pair_mode: pgc_pair_mode_t'(pin_ff[PIN_MODE_LO +: 2])
	};
	assign o_timebase_reset = control_ff[CTL_LIMIT_RESET] & control_ff[CTL_OWN_PERIOD]
		& limit_active;

	// Shared duty reaches the core unchanged
	a_shared_duty: assert property (@(posedge i_clock) disable iff (i_rst)
		control_ff[CTL_SHARED_DUTY] |-> o_core_cfg.duty == i_master_duty)
		else $error("shared duty not selected");

	// Primary period used without own period
	a_primary_period: assert property (@(posedge i_clock) disable iff (i_rst)
		!control_ff[CTL_OWN_PERIOD] |-> o_core_cfg.period == i_primary_period)
		else $error("primary period not selected");

	// Phase image keeps its two low bits clear
	a_phase_low: assert property (@(posedge i_clock) disable iff (i_rst)
		(phase_ff & ~PHASE_WMASK) == 16'h0000)
		else $error("phase low bits set");

	// Interrupt requests follow the pending flags
	assign o_limit_irq = control_ff[CTL_LIMIT_PEND];
	assign o_trigger_irq = control_ff[CTL_TRIG_PEND];
	assign o_trigger_out = trig_out_ff;

	// Enabled limit event raises the request next cycle
	a_limit_pend: assert property (@(posedge i_clock) disable iff (i_rst)
		limit_active && control_ff[CTL_LIMIT_IEN] && !wr_ctl |=> o_limit_irq)
		else $error("limit event did not set pending");

	// Disabled trigger interrupt shows no request
	a_trig_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		!control_ff[CTL_TRIG_IEN] |-> !o_trigger_irq)
		else $error("trigger request while disabled");

	// Pin data: fault over limit over override over generator, then polarity
	wire [1:0] ovr_next = pin_ff[PIN_OVR_LO +: 2];
	wire ovr_load = ~pin_ff[PIN_OVERRIDE_SYNC] | i_evt.cycle_start;
	wire hi_data = fault_active ? pin_ff[PIN_FLT_LO + 1]
		: limit_active ? pin_ff[PIN_LIM_LO + 1]
		: pin_ff[PIN_HI_OVR] ? active_ovr_ff[1] : i_gen_high;
	wire lo_data = fault_active ? pin_ff[PIN_FLT_LO]
		: limit_active ? pin_ff[PIN_LIM_LO]
		: pin_ff[PIN_LO_OVR] ? active_ovr_ff[0] : i_gen_low;
	wire hi_pin = pin_ff[PIN_HI_OWN] ? (hi_data ^ pin_ff[PIN_HI_INV]) : i_gpio_high;
	wire lo_pin = pin_ff[PIN_LO_OWN] ? (lo_data ^ pin_ff[PIN_LO_INV]) : i_gpio_low;
	assign o_high_side_output = high_ff;
	assign o_low_side_output = low_ff;
	assign o_high_pin_owner = pin_ff[PIN_HI_OWN];
	assign o_low_pin_owner = pin_ff[PIN_LO_OWN];

	// Unowned high pin follows the port data
	a_high_gpio: assert property (@(posedge i_clock) disable iff (i_rst)
		!pin_ff[PIN_HI_OWN] |=> high_ff == $past(i_gpio_high))
		else $error("high pin not port data");

	// Unowned low pin follows the port data
	a_low_gpio: assert property (@(posedge i_clock) disable iff (i_rst)
		!pin_ff[PIN_LO_OWN] |=> low_ff == $past(i_gpio_low))
		else $error("low pin not port data");

	// Override value drives the high pin
	a_high_override: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ff[PIN_HI_OWN] && pin_ff[PIN_HI_OVR] && !fault_active && !limit_active |=>
		high_ff == $past(active_ovr_ff[1] ^ pin_ff[PIN_HI_INV]))
		else $error("override not on high pin");

	// Generator drives the high pin when nothing overrides
	a_high_gen: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ff[PIN_HI_OWN] && !pin_ff[PIN_HI_OVR] && !fault_active && !limit_active |=>
		high_ff == $past(i_gen_high ^ pin_ff[PIN_HI_INV]))
		else $error("generator not on high pin");

	// Limit value drives the high pin
	a_high_limit: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ff[PIN_HI_OWN] && limit_active && !fault_active |=>
		high_ff == $past(pin_ff[PIN_LIM_LO + 1] ^ pin_ff[PIN_HI_INV]))
		else $error("limit data not on high pin");

	// Limit value drives the low pin
	a_low_limit: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ff[PIN_LO_OWN] && limit_active && !fault_active |=>
		low_ff == $past(pin_ff[PIN_LIM_LO] ^ pin_ff[PIN_LO_INV]))
		else $error("limit data not on low pin");

	// Fault value drives the low pin
	a_low_fault: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ff[PIN_LO_OWN] && fault_active |=>
		low_ff == $past(pin_ff[PIN_FLT_LO] ^ pin_ff[PIN_LO_INV]))
		else $error("fault data not on low pin");

	// Trigger postscaler
	wire [2:0] trig_div = trigger_ff[TRG_DIV_LO +: 3];
	wire start_match = i_evt.roll_count == trigger_ff[5:0];
	wire post_run = post_run_ff | start_match;
	wire trig_hit = i_evt.trigger_event & post_run & (post_count_ff == trig_div);

	// Control register next value: a cleared enable blocks the hardware set
	logic [15:0] nxt_control;
	always_comb begin
		nxt_control = control_ff;
		if (wr_ctl)
			nxt_control = merge(control_ff, CTL_WMASK, bemask, wdata);
		if (!nxt_control[CTL_LIMIT_IEN])
			nxt_control[CTL_LIMIT_PEND] = 1'b0;
		if (!nxt_control[CTL_TRIG_IEN])
			nxt_control[CTL_TRIG_PEND] = 1'b0;
		if (limit_active && nxt_control[CTL_LIMIT_IEN])
			nxt_control[CTL_LIMIT_PEND] = 1'b1;
		if (trig_hit && nxt_control[CTL_TRIG_IEN])
			nxt_control[CTL_TRIG_PEND] = 1'b1;
	end

	// Read data mux
	logic [15:0] nxt_rd;
	always_comb begin
		unique case (avs_address)
			OFF_CONTROL: nxt_rd = control_ff;
			OFF_DUTY: nxt_rd = duty_ff;
			OFF_PHASE: nxt_rd = phase_ff;
			OFF_DEAD: nxt_rd = dead_ff;
			OFF_ALT_DEAD: nxt_rd = alt_dead_ff;
			OFF_TRIGGER: nxt_rd = trigger_ff;
			OFF_PIN_IO: nxt_rd = pin_ff;
			OFF_FAULT_LIMIT: nxt_rd = fcl_ff;
			default: nxt_rd = 16'h0000;
		endcase
	end

	// Bus handshake and read data
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
			readdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= access;
			readdata_ff <= access ? {16'h0000, nxt_rd} : readdata_ff;
		end
	end

	// Register file
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			control_ff <= REG_RESET;
			duty_ff <= REG_RESET;
			phase_ff <= REG_RESET;
			dead_ff <= REG_RESET;
			alt_dead_ff <= REG_RESET;
			trigger_ff <= REG_RESET;
			pin_ff <= REG_RESET;
			fcl_ff <= REG_RESET;
		end else begin
			control_ff <= nxt_control;
			if (wr_duty) duty_ff <= merge(duty_ff, 16'hffff, bemask, wdata);
			if (wr_phase) phase_ff <= merge(phase_ff, PHASE_WMASK, bemask, wdata);
			if (wr_dead) dead_ff <= merge(dead_ff, DEAD_WMASK, bemask, wdata);
			if (wr_alt) alt_dead_ff <= merge(alt_dead_ff, DEAD_WMASK, bemask, wdata);
			if (wr_trig) trigger_ff <= merge(trigger_ff, TRIG_WMASK, bemask, wdata);
			if (wr_pin) pin_ff <= merge(pin_ff, PIN_WMASK, bemask, wdata);
			if (wr_fcl) fcl_ff <= merge(fcl_ff, FCL_WMASK, bemask, wdata);
		end
	end

	// Active duty and override images
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			active_duty_ff <= REG_RESET;
			active_ovr_ff <= 2'h0;
		end else begin
			if (control_ff[CTL_INSTANT] || i_evt.cycle_start)
				active_duty_ff <= duty_ff;
			if (ovr_load)
				active_ovr_ff <= ovr_next;
		end
	end

	// Instant load copies the duty register every cycle
	a_duty_instant: assert property (@(posedge i_clock) disable iff (i_rst)
		control_ff[CTL_INSTANT] |=> active_duty_ff == $past(duty_ff))
		else $error("instant duty not applied");

	// Synchronized override waits for a cycle start
	a_ovr_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ff[PIN_OVERRIDE_SYNC] && !i_evt.cycle_start |=> $stable(active_ovr_ff))
		else $error("override changed outside cycle");

	// Trigger postscaler counter and output pulse
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			post_count_ff <= 3'h0;
			post_run_ff <= 1'b0;
			trig_out_ff <= 1'b0;
		end else begin
			post_run_ff <= post_run;
			trig_out_ff <= trig_hit;
			if (i_evt.trigger_event && post_run)
				post_count_ff <= trig_hit ? 3'h0 : post_count_ff + 3'h1;
		end
	end

	// Each output pulse restarts the event count
	a_trig_div: assert property (@(posedge i_clock) disable iff (i_rst)
		o_trigger_out |-> post_count_ff == 3'h0)
		else $error("divider not restarted");

	// Registered pin drive
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			high_ff <= 1'b0;
			low_ff <= 1'b0;
		end else begin
			high_ff <= hi_pin;
			low_ff <= lo_pin;
		end
	end

	// Clearing the limit enable leaves no pending flag
	a_limit_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		!control_ff[CTL_LIMIT_IEN] |-> !control_ff[CTL_LIMIT_PEND])
		else $error("limit pending set while disabled");
	// Trigger pending follows an enabled hit
	a_trig_pend: assert property (@(posedge i_clock) disable iff (i_rst)
		trig_hit && control_ff[CTL_TRIG_IEN] && !wr_ctl |=> o_trigger_irq)
		else $error("trigger hit did not set pending");
	// Period comes from the chosen source
	a_period_src: assert property (@(posedge i_clock) disable iff (i_rst)
		control_ff[CTL_OWN_PERIOD] |-> o_core_cfg.period == (phase_ff & PERIOD_MASK))
		else $error("period source wrong");
	// Duty holds while synchronized and no cycle start
	a_duty_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		!control_ff[CTL_INSTANT] && !i_evt.cycle_start |=> $stable(active_duty_ff))
		else $error("duty changed outside cycle");
	// Time base reset needs own period
	a_tb_reset: assert property (@(posedge i_clock) disable iff (i_rst)
		o_timebase_reset |-> control_ff[CTL_OWN_PERIOD] && control_ff[CTL_LIMIT_RESET])
		else $error("time base reset without own period");
	// Dead-time images keep unimplemented bits clear
	a_dead_bits: assert property (@(posedge i_clock) disable iff (i_rst)
		(dead_ff & ~DEAD_WMASK) == 16'h0000 && (alt_dead_ff & ~DEAD_WMASK) == 16'h0000)
		else $error("dead-time reserved bits set");
	// Fault value reaches an owned high pin a cycle later
	a_fault_pin: assert property (@(posedge i_clock) disable iff (i_rst)
		fault_active && pin_ff[PIN_HI_OWN] |=>
		high_ff == ($past(pin_ff[PIN_FLT_LO + 1]) ^ $past(pin_ff[PIN_HI_INV])))
		else $error("fault data not on high pin");
	// Trigger output only after postscaler started
	a_trig_start: assert property (@(posedge i_clock) disable iff (i_rst)
		o_trigger_out |-> $past(post_run))
		else $error("trigger before start match");
endmodule : pgc_channel

// ---- verification/pgc_supply_model.sv ----
// Behavioural model of the comparators and fault lines feeding the channel
module pgc_supply_model (
	input wire logic i_clock,
	input wire logic [3:0] i_cmp_set,
	input wire logic [3:0] i_sflt_set,
	input wire logic [3:0] i_iflt_set,
	output logic [3:0] o_comparator,
	output logic [3:0] o_shared_fault,
	output logic [3:0] o_indep_fault
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sensor levels settle one clock after the bench asks for them
	always @(posedge i_clock) begin
		o_comparator <= i_cmp_set;
		o_shared_fault <= i_sflt_set;
		o_indep_fault <= i_iflt_set;
	end
endmodule : pgc_supply_model

// ---- verification/pgc_channel_test.sv ----
// Self-checking bench for the channel control block
module pgc_channel_test;
	import pgc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0, i_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic avs_waitrequest, gen_h = 1'b0, gen_l = 1'b0, gpio_h = 1'b0, gpio_l = 1'b0;
	logic [15:0] master_duty = 16'h4321, prim_period = 16'h0100, rd;
	logic [3:0] cmp_set = 4'h0, sflt_set = 4'h0, iflt_set = 4'h0, cmp, sflt, iflt;
	// Idle roll value matches no start value that the tests program
	pgc_core_evt_t evt = '{cycle_start: 1'b0, trigger_event: 1'b0, roll_count: 6'h2a};
	logic [3:0] be = 4'h3;
	pgc_core_cfg_t cfg;
	logic tb_rst, trg_out, lim_irq, trg_irq, hi_pin, lo_pin, hi_own, lo_own;
	int errors = 0, total_checks = 0, trg_seen = 0;
	logic [4:0] offs[8] = '{OFF_CONTROL, OFF_DUTY, OFF_PHASE, OFF_DEAD, OFF_ALT_DEAD,
		OFF_TRIGGER, OFF_PIN_IO, OFF_FAULT_LIMIT};
	logic [15:0] masks[8] = '{CTL_WMASK, 16'hffef, PHASE_WMASK, DEAD_WMASK, DEAD_WMASK,
		TRIG_WMASK, PIN_WMASK, FCL_WMASK};
	// Clock and trigger pulse counter
	always #5 i_clock = ~i_clock;
	always @(posedge i_clock) if (trg_out === 1'b1) trg_seen <= trg_seen + 1;
	pgc_supply_model supply (.i_clock(i_clock), .i_cmp_set(cmp_set), .i_sflt_set(sflt_set),
		.i_iflt_set(iflt_set), .o_comparator(cmp), .o_shared_fault(sflt),
		.o_indep_fault(iflt));
	pgc_channel dut (.i_clock(i_clock), .i_rst(i_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .i_master_duty(master_duty),
		.i_primary_period(prim_period), .i_evt(evt), .i_gen_high(gen_h), .i_gen_low(gen_l),
		.i_gpio_high(gpio_h), .i_gpio_low(gpio_l), .i_comparator(cmp),
		.i_shared_fault(sflt), .i_indep_fault(iflt), .o_core_cfg(cfg),
		.o_timebase_reset(tb_rst), .o_trigger_out(trg_out), .o_limit_irq(lim_irq),
		.o_trigger_irq(trg_irq), .o_high_side_output(hi_pin), .o_low_side_output(lo_pin),
		.o_high_pin_owner(hi_own), .o_low_pin_owner(lo_own));
	// Comparison with report
	task check(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// One bus access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {16'h0, d};
		do begin
			@(posedge i_clock);
			n++;
		end while (avs_waitrequest !== 1'b0);
		check("wait edges", 16'h2, 16'(n));
		rd = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task rd_chk(input string name, input logic [4:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0);
		check(name, exp, rd);
	endtask : rd_chk
	task pins(input logic h, input logic l);
		repeat (4) @(posedge i_clock);
		check("high pin", {15'h0, h}, {15'h0, hi_pin});
		check("low pin", {15'h0, l}, {15'h0, lo_pin});
	endtask : pins
	task pulse_trig(input int k);
		repeat (k) begin
			@(posedge i_clock) evt.trigger_event <= 1'b1;
			@(posedge i_clock) evt.trigger_event <= 1'b0;
			repeat (2) @(posedge i_clock);
		end
	endtask : pulse_trig
	// Verdict and end of run
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge i_clock);
		errors++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		// Reset values, writable masks, reserved bits
		for (int i = 0; i < 8; i++) rd_chk("reset value", offs[i], REG_RESET);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, offs[i], 16'hffff & masks[i]);
			rd_chk("mask readback", offs[i], masks[i]);
		end
		check("dead time", 16'h3ffc, cfg.dead_time);
		check("alt dead time", 16'h3ffc, cfg.alt_dead_time);
		check("own period", 16'hfff0, cfg.period);
		for (int i = 0; i < 8; i++) bus(1'b1, offs[i], 16'h0);
		$display("test registers done");
		// Period and duty source selection, duty loading
		check("primary period", prim_period, cfg.period);
		bus(1'b1, OFF_CONTROL, 16'h0100);
		@(posedge i_clock);
		check("shared duty", master_duty, cfg.duty);
		bus(1'b1, OFF_CONTROL, 16'h0001);
		bus(1'b1, OFF_DUTY, 16'h1234);
		repeat (2) @(posedge i_clock);
		check("instant duty", 16'h1234, cfg.duty);
		bus(1'b1, OFF_CONTROL, 16'h0000);
		bus(1'b1, OFF_DUTY, 16'h0008);
		repeat (3) @(posedge i_clock);
		check("held duty", 16'h1234, cfg.duty);
		@(posedge i_clock) evt.cycle_start <= 1'b1;
		@(posedge i_clock) evt.cycle_start <= 1'b0;
		@(posedge i_clock);
		check("synced duty", 16'h0008, cfg.duty);
		be <= 4'h1;
		bus(1'b1, OFF_DUTY, 16'habcd);
		be <= 4'h3;
		rd_chk("lane write", OFF_DUTY, 16'h00cd);
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, OFF_CONTROL, 16'(m) << 6);
			@(posedge i_clock);
			check("dead mode", 16'(m), 16'(cfg.dead_mode));
			bus(1'b1, OFF_PIN_IO, 16'(m) << 10);
			@(posedge i_clock);
			check("pair mode", 16'(m), 16'(cfg.pair_mode));
		end
		$display("test config done");
		// Trigger start match, divider and interrupt
		bus(1'b1, OFF_TRIGGER, 16'h4005);
		bus(1'b1, OFF_CONTROL, 16'h0400);
		pulse_trig(3);
		check("trigger before match", 16'h0, 16'(trg_seen));
		@(posedge i_clock) evt.roll_count <= 6'h05;
		@(posedge i_clock) evt.roll_count <= 6'h2a;
		pulse_trig(9);
		check("trigger count", 16'h3, 16'(trg_seen));
		check("trigger irq", 16'h1, {15'h0, trg_irq});
		rd_chk("trigger pending", OFF_CONTROL, 16'h2400);
		bus(1'b1, OFF_CONTROL, 16'h0000);
		@(posedge i_clock);
		check("trigger irq off", 16'h0, {15'h0, trg_irq});
		$display("test trigger done");
		// Current limit from comparator two
		bus(1'b1, OFF_FAULT_LIMIT, 16'h0283);
		bus(1'b1, OFF_PIN_IO, 16'hc008);
		bus(1'b1, OFF_CONTROL, 16'h0a02);
		cmp_set <= 4'h2;
		pins(1'b1, 1'b0);
		check("limit irq", 16'h1, {15'h0, lim_irq});
		check("time base reset", 16'h1, {15'h0, tb_rst});
		rd_chk("limit pending", OFF_CONTROL, 16'h4a02);
		check("own period select", 16'h1, {15'h0, cfg.own_period_select});
		bus(1'b1, OFF_CONTROL, 16'h0002);
		@(posedge i_clock);
		check("limit irq off", 16'h0, {15'h0, lim_irq});
		check("no reset", 16'h0, {15'h0, tb_rst});
		rd_chk("limit cleared", OFF_CONTROL, 16'h0002);
		gen_l <= 1'b1;
		bus(1'b1, OFF_FAULT_LIMIT, 16'h0383);
		pins(1'b0, 1'b1);
		cmp_set <= 4'h0;
		pins(1'b1, 1'b0);
		$display("test limit done");
		// Fault from independent input two
		bus(1'b1, OFF_FAULT_LIMIT, 16'h0069);
		bus(1'b1, OFF_PIN_IO, 16'hc020);
		iflt_set <= 4'h2;
		pins(1'b1, 1'b0);
		bus(1'b1, OFF_FAULT_LIMIT, 16'h006d);
		pins(1'b0, 1'b1);
		bus(1'b1, OFF_FAULT_LIMIT, 16'h006b);
		pins(1'b0, 1'b1);
		iflt_set <= 4'h0;
		$display("test fault done");
		// Override, polarity and ownership
		bus(1'b1, OFF_FAULT_LIMIT, 16'h0003);
		bus(1'b1, OFF_PIN_IO, 16'hc380);
		pins(1'b1, 1'b0);
		bus(1'b1, OFF_PIN_IO, 16'hc341);
		pins(1'b1, 1'b0);
		@(posedge i_clock) evt.cycle_start <= 1'b1;
		@(posedge i_clock) evt.cycle_start <= 1'b0;
		pins(1'b0, 1'b1);
		bus(1'b1, OFF_PIN_IO, 16'hf380);
		pins(1'b0, 1'b1);
		gpio_h <= 1'b1;
		bus(1'b1, OFF_PIN_IO, 16'h0000);
		pins(1'b1, 1'b0);
		check("owner bits", 16'h0, {14'h0, hi_own, lo_own});
		$display("test pins done");
		complete_run();
	end
endmodule : pgc_channel_test
